// [rtl/hefp_pkg.sv]
`default_nettype none
package hefp_pkg;
  // ----------------------------------------
  // timing points, in bit times before eof
  // ----------------------------------------
  localparam logic [15:0] HS_EOF1_OFS = 16'h0230; // 560
  localparam logic [15:0] HS_EOF2_OFS = 16'h0040; // 64
  localparam logic [15:0] FS_EOF1_OFS = 16'h0020; // 32
  localparam logic [15:0] FS_EOF2_OFS = 16'h000a; // 10
  // sof decode advance, chosen inside the allowed ranges
  localparam logic [15:0] HS_ADVANCE = 16'h0040; // 64, range 40..192
  localparam logic [15:0] FS_ADVANCE = 16'h0010; // 16, range 16..20
  // rollover limits of the interval counter
  localparam logic [15:0] HS_ROLL = 16'heac0; // 60096
  localparam logic [15:0] FS_ROLL = 16'h2f0a; // 12042
  // host side nominal intervals
  localparam logic [15:0] HS_NOMINAL = 16'hea60; // 60000
  localparam logic [15:0] FS_NOMINAL = 16'h2ee0; // 12000
  // transaction translator sof period: 8 microframes
  localparam logic [2:0] TT_UFRAMES = 3'h7;
  // bit clock of the block is 100 MHz, 10 ns
  localparam int CLK_PERIOD_NS = 10;
  localparam int TT_JITTER_NS = 42;
  localparam int TT_JITTER_CYC = (TT_JITTER_NS / CLK_PERIOD_NS < 1) ?
    1 : TT_JITTER_NS / CLK_PERIOD_NS;
  localparam logic [4:0] HS_DIV = 5'h10; // babble check clock divider
  localparam logic [4:0] REP_JITTER_MAX = 5'h05;
  localparam logic [4:0] SOF_JITTER_MAX = 5'h10;
  localparam logic [4:0] HOST_JITTER_MAX = 5'h04;

  typedef enum logic [1:0] {
    HEFP_UNSYNC,
    HEFP_FIRST,
    HEFP_LOCKED
  } hefp_sync_type;
endpackage
`default_nettype wire

// [rtl/hefp_link_if.sv]
`default_nettype none
interface hefp_link_if;
  logic sof;          // sof token seen on the upstream link, pulse
  logic hs_mode;      // high-speed signalling in use
  logic host_eof1;    // host reached its eof1 point
  logic host_eof2;    // host reached its eof2 point
  logic up_eop;       // hub drives eop upstream, pulse
  logic up_active;    // hub repeating upstream traffic
  modport hub (input sof, input hs_mode, input host_eof1,
    input host_eof2, output up_eop, output up_active);
  modport host (output sof, output hs_mode, output host_eof1,
    output host_eof2, input up_eop, input up_active);
endinterface
`default_nettype wire

// [rtl/hefp_host.sv]
`default_nettype none
// ----------------------------------------
// upstream host frame source
// ----------------------------------------
module hefp_host
  import hefp_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic hs_sel,
  hefp_link_if.host link,
  output logic late_ok
);
  logic [15:0] cnt_r, cnt_nxt;
  logic sof_r, sof_nxt;
  logic e1_r, e1_nxt;
  logic e2_r, e2_nxt;
  logic ok_r, ok_nxt;
  logic hs_r, hs_nxt;

  // fixed interval, never altered once running zero jitter
  // so the source stays under its jitter limit
  always_comb begin
    hs_nxt = hs_r;
    sof_nxt = 1'b0;
    cnt_nxt = cnt_r;
    if (!enable) begin
      cnt_nxt = 16'h0000;
      hs_nxt = hs_sel;
    end else if (cnt_r == 16'h0000) begin
      sof_nxt = 1'b1;
      cnt_nxt = (hs_r ? HS_NOMINAL : FS_NOMINAL) - 16'h0001;
    end else begin
      cnt_nxt = cnt_r - 16'h0001;
    end
    // host eof points match the hub table
    e1_nxt = enable && cnt_r == (hs_r ? HS_EOF1_OFS : FS_EOF1_OFS);
    e2_nxt = enable && cnt_r == (hs_r ? HS_EOF2_OFS : FS_EOF2_OFS);
    // truncated packets after eof1 are discarded
    ok_nxt = enable && cnt_r > (hs_r ? HS_EOF1_OFS : FS_EOF1_OFS);
  end

  // host state registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 16'h0000;
      sof_r <= 1'b0;
      e1_r <= 1'b0;
      e2_r <= 1'b0;
      ok_r <= 1'b0;
      hs_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sof_r <= sof_nxt;
      e1_r <= e1_nxt;
      e2_r <= e2_nxt;
      ok_r <= ok_nxt;
      hs_r <= hs_nxt;
    end
  end

  assign link.sof = sof_r;
  assign link.hs_mode = hs_r;
  assign link.host_eof1 = e1_r;
  assign link.host_eof2 = e2_r;
  assign late_ok = ok_r;
endmodule
`default_nettype wire

// [rtl/hefp_hub.sv]
// Contract
// - timer signals lock when synced to sof
// - block downstream connectivity until locked after resume
// - translator sof interval within 42 ns
// - translator sofs and keepalives from microframe count
// - repeater sof jitter between 0 and 5
// - sof detection jitter at most 16 bits
// - host sof jitter below 4 bits
// - high-speed eof2 64, eof1 560
// - full-speed eof1 32, eof2 10
// - eof points ignored while unlocked
// - eof2 disables ports with upstream connectivity
// - full-speed eof1 sends eop upstream
// - high-speed eof1 tears down upstream connectivity
// - high-speed release on idle and drained buffer
// - abrupt high-speed end must not upset repeater
// - high-speed babble check on bit clock over 16
// - host keeps microframe interval fixed after sync
// - reset or resume unsyncs; two sofs lock
// - interval above limit is rollover, no reload
// - eof points advanced by sof decode delay
`default_nettype none
module hefp_hub
  import hefp_pkg::*;
#(
  parameter int NPORTS = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic bus_reset,
  input wire logic resume,
  hefp_link_if.hub link,
  input wire logic [NPORTS-1:0] port_sop,
  input wire logic [NPORTS-1:0] port_idle,
  input wire logic elastic_empty,
  output logic [NPORTS-1:0] port_conn,
  output logic [NPORTS-1:0] port_babble,
  output logic locked,
  output logic eof1_pulse,
  output logic eof2_pulse,
  output logic tt_sof,
  output logic tt_keepalive
);
  // ----------------------------------------
  // frame timer and synchronisation
  // ----------------------------------------
  hefp_sync_type sync_r, sync_nxt;
  logic [15:0] cur_r, cur_nxt;   // interval up counter
  logic [15:0] tmr_r, tmr_nxt;   // frame down counter, eof at zero
  logic [15:0] next_r, next_nxt; // next interval
  logic roll_r, roll_nxt;
  logic [15:0] roll_lim, eof1_at, eof2_at;

  // speed select picks offsets, advanced by decode delay
  always_comb begin
    roll_lim = link.hs_mode ? HS_ROLL : FS_ROLL;
    eof1_at = link.hs_mode ? HS_EOF1_OFS + HS_ADVANCE :
      FS_EOF1_OFS + FS_ADVANCE;
    eof2_at = link.hs_mode ? HS_EOF2_OFS + HS_ADVANCE :
      FS_EOF2_OFS + FS_ADVANCE;
  end

  // timer next state
  always_comb begin
    sync_nxt = sync_r;
    cur_nxt = cur_r;
    tmr_nxt = tmr_r;
    next_nxt = next_r;
    roll_nxt = roll_r;
    if (sync_r != HEFP_UNSYNC && !roll_r) begin
      cur_nxt = cur_r + 16'h0001;
      if (cur_r >= roll_lim) begin
        roll_nxt = 1'b1;
        sync_nxt = HEFP_FIRST; // missed sof drops lock at once
      end
    end
    if (tmr_r == 16'h0000) tmr_nxt = next_r;
    else tmr_nxt = tmr_r - 16'h0001;
    if (bus_reset || resume) begin
      sync_nxt = HEFP_UNSYNC;
      roll_nxt = 1'b0;
      cur_nxt = 16'h0000;
    end else if (link.sof) begin
      cur_nxt = 16'h0000;
      roll_nxt = 1'b0;
      if (sync_r == HEFP_UNSYNC) begin
        sync_nxt = HEFP_FIRST;
      end else if (roll_r) begin
        tmr_nxt = next_r; // missed sof: no reload
        sync_nxt = HEFP_FIRST;
      end else begin
        // counted sof edge gives at most one count of jitter
        tmr_nxt = cur_r;
        next_nxt = cur_r;
        sync_nxt = HEFP_LOCKED; // second sof locks
      end
    end
  end

  // timer registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_r <= HEFP_UNSYNC;
      cur_r <= 16'h0000;
      tmr_r <= 16'h0000;
      next_r <= 16'h0000;
      roll_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      cur_r <= cur_nxt;
      tmr_r <= tmr_nxt;
      next_r <= next_nxt;
      roll_r <= roll_nxt;
    end
  end

  // ----------------------------------------
  // repeater control
  // ----------------------------------------
  logic lock_nxt, lock_r;
  logic e1_nxt, e1_r, e2_nxt, e2_r;
  logic [NPORTS-1:0] conn_r, conn_nxt, bab_r, bab_nxt;
  logic eop_r, eop_nxt, act_r, act_nxt;

  // eof points act only while locked
  always_comb begin
    lock_nxt = sync_nxt == HEFP_LOCKED;
    e1_nxt = lock_r && tmr_r == eof1_at;
    // hs offsets are multiples of 16: bits 15:4 pick the slot
    e2_nxt = lock_r && (link.hs_mode ?
      tmr_r[15:4] == eof2_at[15:4] && tmr_r[3:0] == 4'h0 :
      tmr_r == eof2_at);
  end

  // per-port connectivity and babble
  always_comb begin
    conn_nxt = conn_r;
    bab_nxt = bab_r;
    for (int i = 0; i < NPORTS; i++) begin
      if (bus_reset || resume) begin
        conn_nxt[i] = 1'b0;
        bab_nxt[i] = 1'b0;
      end else if (e2_r && conn_r[i]) begin
        conn_nxt[i] = 1'b0;
        bab_nxt[i] = 1'b1;
      end else if (e1_r) begin
        conn_nxt[i] = 1'b0;
      end else if (conn_r[i] && link.hs_mode) begin
        // release on idle and empty buffer, not eop
        if (port_idle[i] && elastic_empty) conn_nxt[i] = 1'b0;
      end else if (conn_r[i] && port_idle[i]) begin
        conn_nxt[i] = 1'b0;
      end else if (port_sop[i] && lock_r && !bab_r[i] &&
                   conn_r == '0) begin
        conn_nxt[i] = 1'b1; // blocked until locked
      end
    end
    eop_nxt = e1_r && !link.hs_mode && conn_r != '0;
    act_nxt = conn_nxt != '0;
  end

  // repeater registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_r <= 1'b0;
      e1_r <= 1'b0;
      e2_r <= 1'b0;
      conn_r <= '0;
      bab_r <= '0;
      eop_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      e1_r <= e1_nxt;
      e2_r <= e2_nxt;
      conn_r <= conn_nxt;
      bab_r <= bab_nxt;
      eop_r <= eop_nxt;
      act_r <= act_nxt;
    end
  end

  // ----------------------------------------
  // transaction translator sof source
  // ----------------------------------------
  logic [2:0] uf_r, uf_nxt;
  logic tts_r, tts_nxt, ka_r, ka_nxt;

  // one fs sof per 8 microframe timer expiries, exact count
  always_comb begin
    uf_nxt = uf_r;
    tts_nxt = 1'b0;
    ka_nxt = 1'b0;
    if (lock_r && tmr_r == 16'h0000) begin
      uf_nxt = uf_r + 3'h1;
      if (uf_r == TT_UFRAMES) begin
        tts_nxt = 1'b1;
        ka_nxt = 1'b1;
      end
    end
  end

  // translator registers; fixed latency keeps repeat jitter 0
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      uf_r <= 3'h0;
      tts_r <= 1'b0;
      ka_r <= 1'b0;
    end else begin
      uf_r <= uf_nxt;
      tts_r <= tts_nxt;
      ka_r <= ka_nxt;
    end
  end

  assign port_conn = conn_r;
  assign port_babble = bab_r;
  assign locked = lock_r;
  assign eof1_pulse = e1_r;
  assign eof2_pulse = e2_r;
  assign tt_sof = tts_r;
  assign tt_keepalive = ka_r;
  assign link.up_eop = eop_r;
  assign link.up_active = act_r;
endmodule
`default_nettype wire

// [bench/hefp_link_properties.sv]
`default_nettype none
// ----------------
// link checker
// ----------------
module hefp_link_properties (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sof,
  input wire logic hs_mode,
  input wire logic host_eof1,
  input wire logic host_eof2,
  input wire logic up_eop,
  input wire logic up_active
);
  logic [1:0] sofs_r;
  logic [1:0] sofs_nxt;
  // sofs since reset, held at two
  always_comb begin
    sofs_nxt = sofs_r;
    if (sof && sofs_r != 2'h2) sofs_nxt = sofs_r + 2'h1;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) sofs_r <= 2'h0;
    else sofs_r <= sofs_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // host full-speed eof points stand 22 cycles apart
  sequence s_eof1; host_eof1 && !hs_mode; endsequence
  sequence s_eof2; ##22 host_eof2; endsequence
  property p_gap; s_eof1 |-> s_eof2; endproperty
  property p_e1; host_eof1 |=> !host_eof1; endproperty
  property p_eop; up_eop |=> !up_eop; endproperty
  property p_conn; up_eop |-> $past(up_active); endproperty
  property p_drop; up_eop |=> !up_active; endproperty
  property p_fs; up_eop |-> !hs_mode; endproperty
  property p_act; up_active |-> sofs_r == 2'h2; endproperty
  property p_elock; up_eop |-> sofs_r == 2'h2; endproperty
  a_gap: assert property (p_gap) else $error("eof gap");
  a_e1: assert property (p_e1) else $error("eof1 long");
  a_eop: assert property (p_eop) else $error("eop long");
  a_conn: assert property (p_conn) else $error("eop idle");
  a_drop: assert property (p_drop) else $error("eop held");
  a_fs: assert property (p_fs) else $error("eop in hs");
  a_act: assert property (p_act) else $error("early conn");
  a_elock: assert property (p_elock) else $error("early eop");
endmodule
`default_nettype wire

// [bench/test_hub_eof_point_repeater_control.sv]
`default_nettype none
// ----------------
// host and hub end to end
// ----------------
module test_hub_eof_point_repeater_control
  import hefp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic resume = 1'b0;
  logic bus_reset = 1'b0;
  logic tt_seen = 1'b0;
  logic enable = 1'b0;
  logic elastic_empty = 1'b0;
  logic [3:0] port_sop = 4'h0;
  logic [3:0] port_idle = 4'h0;
  logic [3:0] port_conn, port_babble;
  logic locked, eof1_pulse, eof2_pulse, tt_sof, tt_keepalive, late_ok;
  logic eop_seen = 1'b0;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int t1, t2, d;
  hefp_link_if hefp_link_if_i();
  wire [3:0] evs = {hefp_link_if_i.sof, eof2_pulse, eof1_pulse, locked};
  // 100 MHz clock
  always #5 clock = ~clock;
  // cycle count and sticky upstream eop
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (hefp_link_if_i.up_eop) eop_seen <= 1'b1;
    if (tt_sof || tt_keepalive) tt_seen <= 1'b1;
  end
  hefp_host hefp_host_i (.clock(clock), .arst_n(arst_n), .enable(enable),
    .hs_sel(1'b0), .link(hefp_link_if_i.host), .late_ok(late_ok));
  hefp_hub hefp_hub_i (.clock(clock), .arst_n(arst_n), .bus_reset(bus_reset),
    .resume(resume), .link(hefp_link_if_i.hub), .port_sop(port_sop),
    .port_idle(port_idle), .elastic_empty(elastic_empty),
    .port_conn(port_conn), .port_babble(port_babble), .locked(locked),
    .eof1_pulse(eof1_pulse), .eof2_pulse(eof2_pulse), .tt_sof(tt_sof),
    .tt_keepalive(tt_keepalive));
  hefp_link_properties chk (.clock(clock), .arst_n(arst_n),
    .sof(hefp_link_if_i.sof), .hs_mode(hefp_link_if_i.hs_mode),
    .host_eof1(hefp_link_if_i.host_eof1),
    .host_eof2(hefp_link_if_i.host_eof2),
    .up_eop(hefp_link_if_i.up_eop), .up_active(hefp_link_if_i.up_active));
  // compare and count
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // sample just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // bounded wait on locked, eof1, eof2 or sof
  task automatic wait_for(input int sel, input int bound);
    int k;
    k = 0;
    while (evs[sel] !== 1'b1) begin
      tick(1);
      k++;
      if (k > bound) begin
        fails++;
        $display("mismatch wait %0d expected 1 seen 0", sel);
        give_verdict();
      end
    end
  endtask
  // one cycle connect request
  task automatic pulse_sop(input logic [3:0] v);
    @(posedge clock);
    port_sop <= v;
    @(posedge clock);
    port_sop <= 4'h0;
    tick(1);
  endtask
  // two sofs bring lock
  task automatic lock_up();
    wait_for(3, 13000);
    t1 = cyc;
    check("one sof", locked, 1'b0);
    tick(1);
    wait_for(3, 13000);
    t2 = cyc;
    check("sof period", 16'(t2 - t1), FS_NOMINAL);
    tick(2);
    check("locked", locked, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    tick(2);
    pulse_sop(4'h1);
    check("conn early", port_conn, 4'h0);
    @(posedge clock);
    enable <= 1'b1;
    lock_up();
    $display("lock done");
    // release on idle bus and empty buffer
    pulse_sop(4'h1);
    check("conn", port_conn, 4'h1);
    check("active", hefp_link_if_i.up_active, 1'b1);
    @(posedge clock);
    port_idle <= 4'h1;
    elastic_empty <= 1'b1;
    tick(3);
    check("idle drop", port_conn, 4'h0);
    @(posedge clock);
    port_idle <= 4'h0;
    elastic_empty <= 1'b0;
    $display("release done");
    // eof1 ends traffic, eof2 catches a babbler
    pulse_sop(4'h1);
    wait_for(1, 13000);
    t1 = cyc;
    check("late open", late_ok, 1'b1);
    tick(3);
    check("eof1 conn", port_conn, 4'h0);
    check("eop", eop_seen, 1'b1);
    pulse_sop(4'h2);
    wait_for(2, 40);
    t2 = cyc;
    check("late closed", late_ok, 1'b0);
    check("gap", 16'(t2 - t1), FS_EOF1_OFS - FS_EOF2_OFS);
    tick(2);
    check("babble", port_babble, 4'h2);
    wait_for(3, 60);
    d = cyc - t2 - int'(FS_EOF2_OFS + FS_ADVANCE);
    check("advance", d > -4 && d < 4, 1'b1);
    $display("eof done");
    // resume drops lock and babble
    @(posedge clock);
    resume <= 1'b1;
    @(posedge clock);
    resume <= 1'b0;
    tick(2);
    check("resume lock", locked, 1'b0);
    check("resume babble", port_babble, 4'h0);
    pulse_sop(4'h4);
    check("conn resumed", port_conn, 4'h0);
    lock_up();
    $display("resume done");
    // host stops, rollover clears lock
    @(posedge clock);
    enable <= 1'b0;
    tick(int'(FS_ROLL) + 200);
    check("missed sof", locked, 1'b0);
    $display("missed done");
    // one sof after rollover, one more relocks; bus reset then unlocks
    @(posedge clock);
    enable <= 1'b1;
    lock_up();
    @(posedge clock);
    bus_reset <= 1'b1;
    @(posedge clock);
    bus_reset <= 1'b0;
    tick(2);
    check("reset lock", locked, 1'b0);
    // fewer than eight locked expiries: no translator sof yet
    check("tt sof", tt_seen, 1'b0);
    $display("bus reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
